// ===== logic/acsp_port.sv
// Serial command, strobe and result port of a successive-approximation converter
`timescale 1ns/100ps
`default_nettype none
module acsp_port #(
    parameter int RES_W      = acsp_pkg::RES_BITS,
    parameter int FIFO_D     = acsp_pkg::FIFO_DEPTH,
    parameter int CONV_DIV   = acsp_pkg::INT_DIV_CYC
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rstn,
    // Serial pins
    input  wire logic             csN,
    input  wire logic             sclk,
    input  wire logic             din,
    output logic                  doutO,
    output logic                  doutOe,
    output logic                  strobeO,
    output logic                  strobeOe,
    // Three-level shutdown pin, resolved by pad comparators
    input  wire logic             shutdownLowIn,
    input  wire logic             shutdownFloatIn,
    // Analog front end
    input  wire logic             compGe,
    output logic      [RES_W-1:0] dacCode,
    output logic      [2:0]       chanSel,
    output logic                  polaritySelect,
    output logic                  inputConfigSelect,
    output logic                  trackEn,
    // Power control
    output logic                  shutdownActive,
    output logic                  refCompInternal,
    output logic                  fullPowerDown,
    output logic                  fastPowerDown
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and serial clock edge detection

    acsp_pkg::acsp_pins_t pinsS;
    logic                 sclkD_r;
    logic                 sclkRise, sclkFall;
    logic                 csHigh, csFall, csD_r;

    // Reset to idle pin levels: no driven result line or false select after reset
    acsp_sync #(
        .W       ($bits(acsp_pkg::acsp_pins_t)),
        .RST     (5'h10)
    ) u_sync (
        .core_clk(core_clk),
        .rstn    (rstn),
        .asyncIn ({csN, sclk, din, shutdownLowIn, shutdownFloatIn}),
        .syncOut (pinsS)
    );

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            sclkD_r <= 1'b0;
            csD_r   <= 1'b1;
        end
        else
        begin
            sclkD_r <= pinsS.sclk;
            csD_r   <= pinsS.csN;
        end
    end

    assign csHigh   = pinsS.csN;
    assign csFall   = csD_r && !pinsS.csN;
    assign sclkRise = pinsS.sclk && !sclkD_r && !csHigh;
    assign sclkFall = !pinsS.sclk && sclkD_r && !csHigh;

    ////////////////////////////////////////////////////////////////////////////
    // Decision FIFO between converter and result shifter

    logic decValid, decReady, bitValid, bitPop, bitData;

    acsp_fifo #(
        .W       (1),
        .D       (FIFO_D)
    ) u_fifo (
        .core_clk(core_clk),
        .rstn    (rstn),
        .flush   (csFall),
        .inValid (decValid),
        .inReady (decReady),
        .inData  (compGe),
        .outValid(bitValid),
        .outReady(bitPop),
        .outData (bitData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Command, acquisition and conversion control

    acsp_pkg::acsp_state_t state_r, state_nxt;
    acsp_pkg::acsp_cmd_t   cmd_r, cmd_nxt;
    logic [3:0]            bitCnt_r, bitCnt_nxt;
    logic [3:0]            decIdx_r, decIdx_nxt;
    logic [RES_W-1:0]      sar_r, sar_nxt;
    logic [7:0]            div_r, div_nxt;
    logic                  strobe_r, strobe_nxt;
    logic                  extMode_r, extMode_nxt;
    logic                  pdFull_r, pdFull_nxt, pdFast_r, pdFast_nxt;
    logic                  decTick, newExt;

    assign newExt = ({cmd_r.powerModeHi, cmd_r.powerModeLo} == acsp_pkg::PM_EXT_CLK);

    always_comb
    begin
        state_nxt   = state_r;
        cmd_nxt     = cmd_r;
        bitCnt_nxt  = bitCnt_r;
        decIdx_nxt  = decIdx_r;
        sar_nxt     = sar_r;
        div_nxt     = div_r;
        strobe_nxt  = strobe_r;
        extMode_nxt = extMode_r;
        pdFull_nxt  = pdFull_r;
        pdFast_nxt  = pdFast_r;
        decTick     = 1'b0;
        // Decision pacing: serial rises in external mode, divider otherwise
        if (state_r == acsp_pkg::ST_CONV)
        begin
            if (extMode_r)
            begin
                decTick = sclkRise;
            end
            else
            begin
                decTick = (div_r == 8'(CONV_DIV - 1));
            end
        end
        decValid = decTick;

        case (state_r)
            acsp_pkg::ST_IDLE, acsp_pkg::ST_DONE:
            begin
                if (sclkRise && pinsS.din)
                begin
                    cmd_nxt    = acsp_pkg::acsp_cmd_t'({pinsS.din, 7'h00});
                    bitCnt_nxt = 4'h1;
                    pdFull_nxt = 1'b0;
                    pdFast_nxt = 1'b0;
                    state_nxt  = acsp_pkg::ST_CMD;
                end
            end
            acsp_pkg::ST_CMD:
            begin
                if (sclkRise)
                begin
                    // Shift in MSB first; bit order is fixed by the struct
                    cmd_nxt = acsp_pkg::acsp_cmd_t'(
                        {cmd_r[6:0], 1'b0} | {7'h00, pinsS.din});
                    cmd_nxt.start = 1'b1;
                    bitCnt_nxt = bitCnt_r + 4'h1;
                    if (bitCnt_r == 4'(acsp_pkg::CMD_BITS - 1))
                    begin
                        state_nxt = acsp_pkg::ST_ACQ;
                    end
                end
            end
            acsp_pkg::ST_ACQ:
            begin
                // Sample is held from the fall after the last command bit
                if (sclkFall)
                begin
                    extMode_nxt = newExt;
                    decIdx_nxt  = 4'(RES_W - 1);
                    sar_nxt     = acsp_pkg::RES_RST;
                    div_nxt     = 8'h00;
                    if (newExt)
                    begin
                        strobe_nxt = 1'b1;
                        state_nxt  = acsp_pkg::ST_STROBE;
                    end
                    else
                    begin
                        strobe_nxt = 1'b0;
                        state_nxt  = acsp_pkg::ST_CONV;
                    end
                end
            end
            acsp_pkg::ST_STROBE:
            begin
                if (sclkFall)
                begin
                    strobe_nxt = 1'b0;
                    state_nxt  = acsp_pkg::ST_CONV;
                end
            end
            acsp_pkg::ST_CONV:
            begin
                div_nxt = (div_r == 8'(CONV_DIV - 1)) ? 8'h00 : div_r + 8'h01;
                // A full FIFO stalls the decision until the reader drains it
                if (decTick && !decReady)
                begin
                    div_nxt = div_r;
                end
                else if (decTick)
                begin
                    sar_nxt[decIdx_r] = compGe;
                    decIdx_nxt = decIdx_r - 4'h1;
                    if (decIdx_r == 4'h0)
                    begin
                        strobe_nxt = extMode_r ? 1'b0 : 1'b1;
                        pdFull_nxt = ({cmd_r.powerModeHi, cmd_r.powerModeLo}
                                      == acsp_pkg::PM_FULL_PD);
                        pdFast_nxt = ({cmd_r.powerModeHi, cmd_r.powerModeLo}
                                      == acsp_pkg::PM_FAST_PD);
                        state_nxt  = acsp_pkg::ST_DONE;
                    end
                end
            end
            default:
            begin
                state_nxt = acsp_pkg::ST_IDLE;
            end
        endcase

        if (decTick && !decReady)
        begin
            decValid = 1'b0;
        end

        // Deselect ends any serially paced phase; internal conversions run on
        if (csHigh && (state_r != acsp_pkg::ST_DONE) && (state_r != acsp_pkg::ST_IDLE)
            && !(state_r == acsp_pkg::ST_CONV && !extMode_r))
        begin
            state_nxt  = acsp_pkg::ST_IDLE;
            strobe_nxt = extMode_r ? 1'b0 : 1'b1;
        end

        if (pinsS.shutdownLow)
        begin
            state_nxt  = acsp_pkg::ST_IDLE;
            strobe_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            state_r   <= acsp_pkg::ST_IDLE;
            cmd_r     <= '0;
            bitCnt_r  <= 4'h0;
            decIdx_r  <= 4'h0;
            sar_r     <= acsp_pkg::RES_RST;
            div_r     <= 8'h00;
            strobe_r  <= 1'b1;
            extMode_r <= 1'b0;
            pdFull_r  <= 1'b0;
            pdFast_r  <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            cmd_r     <= cmd_nxt;
            bitCnt_r  <= bitCnt_nxt;
            decIdx_r  <= decIdx_nxt;
            sar_r     <= sar_nxt;
            div_r     <= div_nxt;
            strobe_r  <= strobe_nxt;
            extMode_r <= extMode_nxt;
            pdFull_r  <= pdFull_nxt;
            pdFast_r  <= pdFast_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result shifter: one decision bit per serial fall, MSB first

    logic dout_r, dout_nxt;

    assign bitPop = sclkFall && bitValid;

    always_comb
    begin
        dout_nxt = dout_r;
        if (csHigh)
        begin
            dout_nxt = 1'b0;
        end
        else if (sclkFall)
        begin
            dout_nxt = bitValid ? bitData : 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            dout_r <= 1'b0;
        end
        else
        begin
            dout_r <= dout_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin and front-end outputs

    assign doutO    = dout_r;
    assign doutOe   = !csHigh;
    assign strobeO  = strobe_r;
    assign strobeOe = extMode_r ? !csHigh : 1'b1;

    // Trial code: decided bits plus the bit under test
    assign dacCode = sar_r | (RES_W'(1) << decIdx_r);

    assign chanSel           = cmd_r.chanSel;
    assign polaritySelect    = cmd_r.polaritySelect;
    assign inputConfigSelect = cmd_r.inputConfigSelect;
    // Tracks from the rise of the fifth of eight command bits, up to the holding fall
    assign trackEn = ((state_r == acsp_pkg::ST_CMD)
                      && (bitCnt_r >= 4'(acsp_pkg::TRACK_FROM)))
                     || (state_r == acsp_pkg::ST_ACQ);

    assign shutdownActive  = pinsS.shutdownLow;
    assign refCompInternal = !pinsS.shutdownLow && !pinsS.shutdownFloat;
    assign fullPowerDown   = pdFull_r;
    assign fastPowerDown   = pdFast_r;

endmodule // acsp_port
`default_nettype wire

// ===== pkg/acsp_pkg.sv
// Shared constants and types for the converter serial control port
package acsp_pkg;

    // Command word and result geometry
    localparam int CMD_BITS      = 8;
    localparam int RES_BITS      = 10;
    localparam int FIFO_DEPTH    = 16;
    localparam int TRACK_FROM    = 5;

    // Power mode field codes; only the all-ones code selects external pacing
    localparam logic [1:0] PM_FULL_PD = 2'h0;
    localparam logic [1:0] PM_FAST_PD = 2'h1;
    localparam logic [1:0] PM_INT_CLK = 2'h2;
    localparam logic [1:0] PM_EXT_CLK = 2'h3;

    // Timing
    localparam int CORE_PERIOD_NS = 25;
    localparam int INT_CONV_PERIOD_NS = 500;
    localparam int INT_DIV_CYC =
        (INT_CONV_PERIOD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

    // Reset values
    localparam logic [RES_BITS-1:0] RES_RST = 10'h000;
    localparam logic [1:0]          PM_RST  = PM_INT_CLK;

    typedef struct packed {
        logic       start;
        logic [2:0] chanSel;
        logic       polaritySelect;
        logic       inputConfigSelect;
        logic       powerModeHi;
        logic       powerModeLo;
    } acsp_cmd_t;

    typedef struct packed {
        logic csN;
        logic sclk;
        logic din;
        logic shutdownLow;
        logic shutdownFloat;
    } acsp_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ACQ,
        ST_STROBE,
        ST_CONV,
        ST_DONE
    } acsp_state_t;

endpackage

// ===== logic/acsp_sync.sv
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
`default_nettype none
module acsp_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // Levels
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] meta_r;

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            meta_r  <= RST;
            syncOut <= RST;
        end
        else
        begin
            meta_r  <= asyncIn;
            syncOut <= meta_r;
        end
    end
endmodule // acsp_sync
`default_nettype wire

// ===== logic/acsp_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module acsp_fifo #(
    parameter int W = 1,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic         flush,
    // Fill side
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    // Drain side
    output logic              outValid,
    input  wire logic         outReady,
    output logic      [W-1:0] outData
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_r, wr_nxt, rd_r, rd_nxt;
    logic         push, pop;

    always_comb
    begin
        inReady  = (wr_r[AW] == rd_r[AW]) || (wr_r[AW-1:0] != rd_r[AW-1:0]);
        outValid = (wr_r != rd_r);
        outData  = mem[rd_r[AW-1:0]];
        push     = inValid && inReady;
        pop      = outValid && outReady;
        wr_nxt   = flush ? '0 : wr_r + (AW+1)'(push);
        rd_nxt   = flush ? '0 : rd_r + (AW+1)'(pop);
    end

    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            wr_r <= '0;
            rd_r <= '0;
        end
        else
        begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end

    // Storage needs no reset; occupancy is tracked by the pointers
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_r[AW-1:0]] <= inData;
        end
    end
endmodule // acsp_fifo
`default_nettype wire

// ===== tb/acsp_port_asserts.sv
// Pin-level concurrent checks for the converter serial port
`timescale 1ns/100ps
`default_nettype none
module acsp_port_asserts #(
    parameter int CONV_DIV = 4
) (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rstn,
    // Serial pins
    input wire logic       csN,
    input wire logic       sclk,
    input wire logic       doutO,
    input wire logic       doutOe,
    input wire logic       strobeO,
    input wire logic       strobeOe,
    // Control and front end
    input wire logic       shutdownLowIn,
    input wire logic       shutdownFloatIn,
    input wire logic [2:0] chanSel,
    input wire logic       trackEn,
    input wire logic       shutdownActive,
    input wire logic       refCompInternal
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    logic [7:0] hiCnt_r;
    logic [7:0] hiCnt_nxt;
    logic [7:0] trkCnt_r;
    logic [7:0] trkCnt_nxt;
    ////////////////////////////////////////
    // Saturating run lengths, so a long idle high never wraps into the pulse window
    always_comb
    begin
        hiCnt_nxt  = (rstn && strobeO) ? hiCnt_r + 8'(hiCnt_r != 8'hff) : 8'h00;
        trkCnt_nxt = (rstn && trackEn) ? trkCnt_r + 8'(trkCnt_r != 8'hff) : 8'h00;
    end
    always_ff @(posedge core_clk)
    begin
        hiCnt_r  <= hiCnt_nxt;
        trkCnt_r <= trkCnt_nxt;
    end
    ////////////////////////////////////////
    // Four samples cover the two-stage pin synchroniser
    sequence deselected;
        csN [*4];
    endsequence
    sequence selected;
        !csN [*4];
    endsequence
    a_dout_released: assert property (deselected |-> !doutOe)
        else $error("result line driven while deselected");
    a_dout_enabled: assert property (selected |-> doutOe)
        else $error("result line not driven while selected");
    a_strobe_enabled: assert property (selected |-> strobeOe)
        else $error("strobe not driven while selected");
    a_strobe_released: assert property (!strobeOe |-> csN || $past(csN) || $past(csN, 2))
        else $error("strobe released without deselect");
    a_dout_on_fall: assert property ($changed(doutO) |->
        (!$past(sclk, 2) && !$past(sclk, 3)) || $past(csN, 4) || csN)
        else $error("result changed away from a falling clock");
    a_strobe_on_fall: assert property ($changed(strobeO) |->
        (!$past(sclk, 2) && !$past(sclk, 3)) || shutdownActive)
        else $error("strobe changed away from a falling clock");
    a_pulse_width: assert property ($fell(strobeO) |->
        (hiCnt_r >= 8'h07 && hiCnt_r <= 8'h09) || hiCnt_r > 8'h14)
        else $error("strobe pulse not one serial period");
    a_track_span: assert property ($fell(trackEn) |-> trkCnt_r inside {[8'h19:8'h1f]})
        else $error("tracking span wrong length");
    a_shutdown_level: assert property (shutdownLowIn [*3] |-> shutdownActive)
        else $error("shutdown not entered");
    a_comp_internal: assert property ((!shutdownLowIn && !shutdownFloatIn) [*3]
        |-> refCompInternal)
        else $error("internal compensation not chosen");
    a_cmd_ignored: assert property (deselected |-> $stable(chanSel))
        else $error("command taken while deselected");
endmodule // acsp_port_asserts

bind acsp_port acsp_port_asserts #(.CONV_DIV(CONV_DIV)) acsp_port_asserts_inst (
    .core_clk(core_clk), .rstn(rstn), .csN(csN), .sclk(sclk), .doutO(doutO),
    .doutOe(doutOe), .strobeO(strobeO), .strobeOe(strobeOe), .shutdownLowIn(shutdownLowIn),
    .shutdownFloatIn(shutdownFloatIn), .chanSel(chanSel), .trackEn(trackEn),
    .shutdownActive(shutdownActive), .refCompInternal(refCompInternal)
);
`default_nettype wire

// ===== tb/acsp_host_model.sv
// Host serial master that frames commands and samples the result line
`timescale 1ns/100ps
`default_nettype none
module acsp_host_model (
    // Lines driven by the host
    output logic      csN,
    output logic      sclk,
    output logic      din,
    // Lines driven by the port
    input  wire logic doutO,
    input  wire logic doutOe,
    input  wire logic strobeO,
    input  wire logic strobeOe
);
    logic doutLine = 1'b0;
    logic strbLine = 1'b1;
    // A released line shows the inverse of its last level, never a held copy
    always @(doutO, doutOe)
        doutLine = doutOe ? doutO : ~doutLine;
    always @(strobeO, strobeOe)
        strbLine = strobeOe ? strobeO : ~strbLine;
    initial
    begin
        csN  = 1'b1;
        sclk = 1'b0;
        din  = 1'b0;
    end
    ////////////////////////////////////////
    task automatic select(input logic lvl);
        #100 csN = lvl;
    endtask
    // Clock stays low between calls; equal halves keep the pacing duty in band
    task automatic bitCycle(input logic d, output logic so, output logic st);
        din = d;
        #100 sclk = 1'b1;
        #99 so = doutLine;
        st = strbLine;
        #1 sclk = 1'b0;
    endtask
endmodule // acsp_host_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the converter serial port
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int CONV_DIV = 4;
    localparam int CONV_CYC = acsp_pkg::RES_BITS * CONV_DIV;
    logic       core_clk, rstn, csN, sclk, din, doutO, doutOe, strobeO, strobeOe;
    logic       shutdownLowIn, shutdownFloatIn, trackEn, shutdownActive, refCompInternal;
    logic       polaritySelect, inputConfigSelect, fullPowerDown, fastPowerDown;
    logic       compGe = 1'b0;
    logic       so, st;
    logic [2:0] chanSel;
    logic [9:0] dacCode, level;
    int         failures, n_tests;
    acsp_port #(.CONV_DIV(CONV_DIV)) acsp_port_inst (
        .core_clk(core_clk), .rstn(rstn), .csN(csN), .sclk(sclk), .din(din),
        .doutO(doutO), .doutOe(doutOe), .strobeO(strobeO), .strobeOe(strobeOe),
        .shutdownLowIn(shutdownLowIn), .shutdownFloatIn(shutdownFloatIn), .compGe(compGe),
        .dacCode(dacCode), .chanSel(chanSel), .polaritySelect(polaritySelect),
        .inputConfigSelect(inputConfigSelect), .trackEn(trackEn),
        .shutdownActive(shutdownActive), .refCompInternal(refCompInternal),
        .fullPowerDown(fullPowerDown), .fastPowerDown(fastPowerDown)
    );
    acsp_host_model acsp_host_model_inst (
        .csN(csN), .sclk(sclk), .din(din), .doutO(doutO), .doutOe(doutOe),
        .strobeO(strobeO), .strobeOe(strobeOe)
    );
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Ideal comparator: the search settles on the analog level itself
    always @(negedge core_clk) compGe <= (level >= dacCode);
    ////////////////////////////////////////
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic clk1(input logic d);
        acsp_host_model_inst.bitCycle(d, so, st);
    endtask
    ////////////////////////////////////////
    task automatic t_deselected;
        repeat (8) clk1(1'b1);
        @(negedge core_clk);
        check("track idle", 10'(trackEn), 10'h0);
        check("strobe idle", 10'(strobeO), 10'h1);
        check("dout oe idle", 10'(doutOe), 10'h0);
        check("strobe oe idle", 10'(strobeOe), 10'h1);
    endtask
    task automatic t_shutdown;
        logic [1:0] pad;
        for (int i = 0; i < 3; i++)
        begin
            pad = 2'(2'h2 >> i);
            {shutdownLowIn, shutdownFloatIn} = pad;
            repeat (4) @(negedge core_clk);
            check("shutdown", 10'(shutdownActive), 10'(pad[1]));
            check("ref comp", 10'(refCompInternal), 10'(pad == 2'h0));
        end
    endtask
    task automatic t_conv(input logic [7:0] cmd, input int zeros, input logic [9:0] lvl);
        logic       ext;
        logic [9:0] res;
        logic [2:0] stb;
        int         k;
        int         lowCyc;
        ext = cmd[1:0] == acsp_pkg::PM_EXT_CLK;
        level = lvl;
        #7;
        acsp_host_model_inst.select(1'b0);
        repeat (zeros) clk1(1'b0);
        for (k = 7; k >= 0; k--)
            clk1(cmd[k]);
        if (ext)
        begin
            // Readout runs to clock 20, one past the ten decision clocks 10 to 19, to see the last bit
            for (k = 9; k <= 20; k++)
            begin
                clk1(1'b0);
                if (k > 10)
                    res[20-k] = so;
                if (k < 12)
                    stb[k-9] = st;
            end
            check("strobe pulse", 10'(stb), 10'h001);
        end
        else
        begin
            for (k = 0; k < 12 && strobeO !== 1'b0; k++)
                @(negedge core_clk);
            check("strobe low", 10'(strobeO), 10'h0);
            for (lowCyc = 0; lowCyc < 400 && strobeO !== 1'b1; lowCyc++)
                @(negedge core_clk);
            // Serial clock is held low until the strobe has risen
            check("conv time", 10'(lowCyc >= CONV_CYC - 2 && lowCyc <= CONV_CYC + 6), 10'h1);
            for (k = 1; k <= 11; k++)
            begin
                clk1(1'b0);
                if (k > 1)
                    res[11-k] = so;
            end
            check("strobe done", 10'(st), 10'h1);
        end
        check("result", res, lvl);
        check("channel", 10'(chanSel), 10'(cmd[6:4]));
        check("fields", 10'({polaritySelect, inputConfigSelect}), 10'(cmd[3:2]));
        check("power flags", 10'({fullPowerDown, fastPowerDown}),
              10'({cmd[1:0] == 2'h0, cmd[1:0] == 2'h1}));
        check("dout oe on", 10'(doutOe), 10'h1);
        check("strobe oe on", 10'(strobeOe), 10'h1);
        acsp_host_model_inst.select(1'b1);
        repeat (6) @(negedge core_clk);
        check("dout oe off", 10'(doutOe), 10'h0);
        check("strobe oe off", 10'(strobeOe), 10'(!ext));
    endtask
    task automatic t_modes;
        logic [9:0] lv [4] = '{10'h155, 10'h000, 10'h3ff, 10'h2b6};
        for (int m = 0; m < 4; m++)
            t_conv({1'b1, 3'(m + 5), m[0], m[1], 2'(m)}, m, lv[m]);
        // Second external run starts with the strobe low, so the pulse is a true pulse
        t_conv(8'hff, 0, 10'h0a5);
    endtask
    ////////////////////////////////////////
    initial
    begin
        rstn        = 1'b0;
        shutdownLowIn   = 1'b0;
        shutdownFloatIn = 1'b0;
        level       = 10'h000;
        failures    = 0;
        n_tests     = 0;
        repeat (4) @(negedge core_clk);
        rstn = 1'b1;
        repeat (4) @(negedge core_clk);
        t_deselected();
        t_shutdown();
        t_modes();
        test_done();
    end
    // Whole run needs about 28 us of link traffic
    initial
    begin
        #200000;
        failures++;
        test_done();
    end
endmodule // tb
`default_nettype wire
